// >>> verilog/txwb_pkg.sv
package txwb_pkg;

   // Register byte offsets on the plain register port
   localparam logic [3:0] REG_INT_STATUS = 4'h0;
   localparam logic [3:0] REG_INT_MASK = 4'h4;
   localparam logic [3:0] REG_PROC_STATE = 4'h8;
   localparam logic [3:0] REG_MODE = 4'hc;

   // Interrupt status bit positions
   localparam int INT_TX_BIT = 0;
   localparam int INT_JABBER_BIT = 3;
   localparam int INT_UNDERRUN_BIT = 5;
   localparam int INT_W = 6;
   localparam logic [5:0] INT_STATUS_RESET = 6'h00;
   localparam logic [5:0] INT_MASK_RESET = 6'h00;

   // Loopback and port selections
   localparam logic [1:0] LOOP_INTERNAL = 2'h1;
   localparam logic [1:0] PORT_TWISTED = 2'h0;
   localparam logic [1:0] PORT_AUI = 2'h1;
   localparam logic [1:0] PORT_EXTERNAL = 2'h2;

   // Operating mode register layout, low six bits
   typedef struct packed {
      logic start;
      logic sqe_enable;
      logic [1:0] port_mode;
      logic [1:0] loopback;
   } mode_s;
   localparam logic [5:0] MODE_RESET = 6'h00;

   // Transmit status word as written back to descriptor memory
   typedef struct packed {
      logic own;
      logic [14:0] rsvd_hi;
      logic error_summary;
      logic jabber_timeout_flag;
      logic [1:0] rsvd_mid;
      logic carrier_dropped_flag;
      logic no_carrier_flag;
      logic late_collision_flag;
      logic excessive_collision_flag;
      logic heartbeat_failure_flag;
      logic [3:0] collision_tally;
      logic link_failure_flag;
      logic fifo_underrun_flag;
      logic postponed_flag;
   } tx_status_s;

   // Collision limits
   localparam logic [4:0] MAX_COLLISIONS = 5'h10;
   localparam logic [6:0] COLL_WINDOW_BYTES = 7'h40;

   // Heartbeat listening window after an attempt ends
   localparam int CLK_PERIOD_NS = 10;
   localparam int HB_WINDOW_NS = 1000;
   localparam logic [7:0] HB_WINDOW_CYC = 8'(HB_WINDOW_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      PROC_STOPPED = 2'b00,
      PROC_RUNNING = 2'b01,
      PROC_SUSPENDED = 2'b10
   } proc_e;

   typedef enum logic [1:0] {
      F_IDLE = 2'b00,
      F_SEND = 2'b01,
      F_HEARTBEAT = 2'b10,
      F_WRITEBACK = 2'b11
   } frame_e;

endpackage

// >>> verilog/tx_status_writeback.sv
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
// Contract
// - Status word bit 31 set means controller owns descriptor, clear means host.
// - Controller clears the ownership bit when the frame is finished.
// - Bit 15 is the OR of the seven error indications.
// - Jabber expiry sets bit 14 and interrupt bit 3, aborts, stops.
// - Bit 11 reports carrier lost; meaningless in internal loopback.
// - Bit 10 reports carrier absent; meaningless in internal loopback.
// - Collision after 64 bytes aborts and sets bit 9.
// - Sixteen successive collisions abort and set bit 8.
// - Bit 7 set when no heartbeat pulse returns after transmission.
// - Twisted pair with quality check disabled forces bit 7 set.
// - Retry after collision skips heartbeat check, bit 7 stays clear.
// - Bits 6 to 3 count collisions before successful transmission.
// - Bit 2 set when link test failed and frame cannot go out.
// - FIFO empty mid-frame aborts, sets bit 1, suspends, interrupts 5 and 0.
// - Bit 0 set when a ready frame had to wait for carrier.
module tx_status_writeback (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic [3:0] reg_addr, // Register byte address
   input wire logic [31:0] reg_wdata, // Register write data
   input wire logic reg_wr, // Register write strobe
   input wire logic reg_rd, // Register read strobe
   output logic [31:0] reg_rdata_r, // Read data, cycle after read strobe
   input wire logic frame_start, // Owned first descriptor of a frame fetched
   input wire logic byte_sent, // One byte went onto the wire
   input wire logic collision, // Collision seen during the attempt
   input wire logic attempt_end, // Last byte of the attempt sent
   input wire logic fifo_empty, // Transmit FIFO ran dry mid-frame
   input wire logic jabber_expired, // Jabber timer ran out
   input wire logic defer_seen, // Frame waited for carrier to clear
   input wire logic link_fail, // Link test failed, same clock
   input wire logic carrier_pin, // Transceiver carrier sense, async
   input wire logic heartbeat_pin, // Transceiver collision test pulse, async
   output logic abort_r, // Abort the current transmission, pulse
   output logic retry_r, // Back off and retry after collision, pulse
   output logic desc_wr_r, // Descriptor status write, pulse
   output logic [31:0] desc_word_r, // Status word to write back
   output logic [1:0] proc_state_r, // Transmit process state
   output logic irq_r // Interrupt, level
);

   txwb_pkg::mode_s mode_r;
   logic [5:0] int_r;
   logic [5:0] mask_r;
   txwb_pkg::proc_e proc_r;
   txwb_pkg::frame_e fst_r;
   txwb_pkg::tx_status_s stat_r;
   txwb_pkg::tx_status_s fin;
   logic [4:0] coll_r;
   logic [4:0] coll_nxt;
   logic [6:0] bytes_r;
   logic carr_seen_r;
   logic was_retry_r;
   logic hb_seen_r;
   logic [7:0] hb_cnt_r;
   logic carr_s1_r, carr_s2_r;
   logic hb_s1_r, hb_s2_r, hb_s3_r;
   logic hb_rise;
   logic jab_ev, uf_ev, coll_ev, late_ev, excess_ev;
   logic [5:0] int_set;
   logic wr_mode;

   // Two-flop synchronisers for transceiver pins
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         carr_s1_r <= 1'b0;
         carr_s2_r <= 1'b0;
         hb_s1_r <= 1'b0;
         hb_s2_r <= 1'b0;
         hb_s3_r <= 1'b0;
      end else begin
         carr_s1_r <= carrier_pin;
         carr_s2_r <= carr_s1_r;
         hb_s1_r <= heartbeat_pin;
         hb_s2_r <= hb_s1_r;
         hb_s3_r <= hb_s2_r;
      end
   end

   // Event decode while sending, jabber first, then underrun, then collision
   assign hb_rise = hb_s2_r & ~hb_s3_r;
   assign jab_ev = (fst_r == txwb_pkg::F_SEND) && jabber_expired;
   assign uf_ev = (fst_r == txwb_pkg::F_SEND) && fifo_empty && !jabber_expired;
   assign coll_ev = (fst_r == txwb_pkg::F_SEND) && collision && !jabber_expired && !fifo_empty;
   assign late_ev = coll_ev && (bytes_r == txwb_pkg::COLL_WINDOW_BYTES);
   assign coll_nxt = coll_r + 5'h01;
   assign excess_ev = coll_ev && !late_ev && (coll_nxt == txwb_pkg::MAX_COLLISIONS);
   assign wr_mode = reg_wr && (reg_addr == txwb_pkg::REG_MODE);

   // Final status word: ownership handed back, summary and loopback masking
   always_comb begin
      fin = stat_r;
      fin.own = 1'b0;
      fin.rsvd_hi = 15'h0000;
      fin.rsvd_mid = 2'h0;
      if (mode_r.loopback == txwb_pkg::LOOP_INTERNAL) begin
         fin.carrier_dropped_flag = 1'b0;
         fin.no_carrier_flag = 1'b0;
      end
      fin.error_summary = fin.fifo_underrun_flag | fin.link_failure_flag
         | fin.excessive_collision_flag | fin.late_collision_flag
         | fin.no_carrier_flag | fin.carrier_dropped_flag
         | fin.jabber_timeout_flag;
   end

   // Frame sequencing and status accumulation
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fst_r <= txwb_pkg::F_IDLE;
         stat_r <= '0;
         coll_r <= 5'h00;
         bytes_r <= 7'h00;
         carr_seen_r <= 1'b0;
         was_retry_r <= 1'b0;
         hb_seen_r <= 1'b0;
         hb_cnt_r <= 8'h00;
      end else begin
         case (fst_r)
            txwb_pkg::F_IDLE: begin
               if (frame_start && proc_r == txwb_pkg::PROC_RUNNING) begin
                  stat_r <= '0;
                  stat_r.own <= 1'b1;
                  coll_r <= 5'h00;
                  bytes_r <= 7'h00;
                  carr_seen_r <= 1'b0;
                  was_retry_r <= 1'b0;
                  if (link_fail && mode_r.port_mode == txwb_pkg::PORT_TWISTED) begin
                     stat_r.link_failure_flag <= 1'b1;
                     fst_r <= txwb_pkg::F_WRITEBACK;
                  end else begin
                     fst_r <= txwb_pkg::F_SEND;
                  end
               end
            end
            txwb_pkg::F_SEND: begin
               if (defer_seen) begin
                  stat_r.postponed_flag <= 1'b1;
               end
               if (jab_ev) begin
                  stat_r.jabber_timeout_flag <= 1'b1;
                  fst_r <= txwb_pkg::F_WRITEBACK;
               end else if (uf_ev) begin
                  stat_r.fifo_underrun_flag <= 1'b1;
                  fst_r <= txwb_pkg::F_WRITEBACK;
               end else if (late_ev) begin
                  stat_r.late_collision_flag <= 1'b1;
                  fst_r <= txwb_pkg::F_WRITEBACK;
               end else if (excess_ev) begin
                  stat_r.excessive_collision_flag <= 1'b1;
                  stat_r.collision_tally <= coll_nxt[3:0];
                  fst_r <= txwb_pkg::F_WRITEBACK;
               end else if (coll_ev) begin
                  coll_r <= coll_nxt;
                  was_retry_r <= 1'b1;
                  bytes_r <= 7'h00;
                  carr_seen_r <= 1'b0;
               end else if (attempt_end) begin
                  stat_r.no_carrier_flag <= ~carr_seen_r & ~carr_s2_r;
                  hb_cnt_r <= txwb_pkg::HB_WINDOW_CYC;
                  hb_seen_r <= hb_rise;
                  fst_r <= txwb_pkg::F_HEARTBEAT;
               end else if (byte_sent) begin
                  if (bytes_r != txwb_pkg::COLL_WINDOW_BYTES) begin
                     bytes_r <= bytes_r + 7'h01;
                  end
                  if (carr_s2_r) begin
                     carr_seen_r <= 1'b1;
                  end else if (carr_seen_r) begin
                     stat_r.carrier_dropped_flag <= 1'b1;
                  end
               end
            end
            txwb_pkg::F_HEARTBEAT: begin
               if (hb_rise) begin
                  hb_seen_r <= 1'b1;
               end
               hb_cnt_r <= hb_cnt_r - 8'h01;
               if (hb_cnt_r <= 8'h01) begin
                  stat_r.collision_tally <= coll_r[3:0];
                  if (was_retry_r) begin
                     stat_r.heartbeat_failure_flag <= 1'b0;
                  end else if (mode_r.port_mode == txwb_pkg::PORT_TWISTED
                               && !mode_r.sqe_enable) begin
                     stat_r.heartbeat_failure_flag <= 1'b1;
                  end else begin
                     stat_r.heartbeat_failure_flag <= ~(hb_seen_r | hb_rise);
                  end
                  fst_r <= txwb_pkg::F_WRITEBACK;
               end
            end
            txwb_pkg::F_WRITEBACK: begin
               stat_r.own <= 1'b0;
               fst_r <= txwb_pkg::F_IDLE;
            end
            default: begin
               fst_r <= txwb_pkg::F_IDLE;
            end
         endcase
      end
   end

   // Commands to the transmit engine
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         abort_r <= 1'b0;
         retry_r <= 1'b0;
      end else begin
         abort_r <= jab_ev | uf_ev | late_ev | excess_ev;
         retry_r <= coll_ev & ~late_ev & ~excess_ev;
      end
   end

   // Single write of complete status with ownership returned
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         desc_wr_r <= 1'b0;
         desc_word_r <= 32'h00000000;
      end else begin
         desc_wr_r <= (fst_r == txwb_pkg::F_WRITEBACK);
         if (fst_r == txwb_pkg::F_WRITEBACK) begin
            desc_word_r <= fin;
         end
      end
   end

   // Transmit process state; hardware events win over software writes
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         proc_r <= txwb_pkg::PROC_STOPPED;
      end else if (jab_ev) begin
         proc_r <= txwb_pkg::PROC_STOPPED;
      end else if (uf_ev) begin
         proc_r <= txwb_pkg::PROC_SUSPENDED;
      end else if (wr_mode) begin
         proc_r <= reg_wdata[5] ? txwb_pkg::PROC_RUNNING : txwb_pkg::PROC_STOPPED;
      end
   end

   // Mode and mask registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_r <= txwb_pkg::MODE_RESET;
         mask_r <= txwb_pkg::INT_MASK_RESET;
      end else begin
         if (wr_mode) begin
            mode_r <= reg_wdata[5:0];
         end
         if (reg_wr && reg_addr == txwb_pkg::REG_INT_MASK) begin
            mask_r <= reg_wdata[5:0];
         end
      end
   end

   // Sticky interrupt status, cleared by read, a new event wins over the clear
   always_comb begin
      int_set = 6'h00;
      int_set[txwb_pkg::INT_JABBER_BIT] = jab_ev;
      int_set[txwb_pkg::INT_UNDERRUN_BIT] = uf_ev;
      int_set[txwb_pkg::INT_TX_BIT] = (fst_r == txwb_pkg::F_WRITEBACK);
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         int_r <= txwb_pkg::INT_STATUS_RESET;
      end else if (reg_rd && reg_addr == txwb_pkg::REG_INT_STATUS) begin
         int_r <= int_set;
      end else begin
         int_r <= int_r | int_set;
      end
   end

   // Interrupt output and process state output
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_r <= 1'b0;
         proc_state_r <= txwb_pkg::PROC_STOPPED;
      end else begin
         irq_r <= |(int_r & mask_r);
         proc_state_r <= proc_r;
      end
   end

   // Read data, zero for unmapped addresses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata_r <= 32'h00000000;
      end else if (reg_rd) begin
         case (reg_addr)
            txwb_pkg::REG_INT_STATUS: reg_rdata_r <= {26'h0000000, int_r};
            txwb_pkg::REG_INT_MASK: reg_rdata_r <= {26'h0000000, mask_r};
            txwb_pkg::REG_PROC_STATE: reg_rdata_r <= {30'h00000000, proc_r};
            txwb_pkg::REG_MODE: reg_rdata_r <= {26'h0000000, mode_r};
            default: reg_rdata_r <= 32'h00000000;
         endcase
      end else begin
         reg_rdata_r <= 32'h00000000;
      end
   end

   // Checks
   a_own_returned: assert property (@(posedge clk) disable iff (sys_rst)
      (fst_r == txwb_pkg::F_SEND && attempt_end && !jabber_expired && !fifo_empty
       && !collision) |-> ##[1:300] (desc_wr_r && !desc_word_r[31]))
      else $error("ownership not returned after attempt end");
   a_summary_or: assert property (@(posedge clk) disable iff (sys_rst)
      desc_wr_r |-> (desc_word_r[15] == (|{desc_word_r[14], desc_word_r[11:8],
                                          desc_word_r[2:1]})))
      else $error("error summary mismatch");
   a_jabber_stop: assert property (@(posedge clk) disable iff (sys_rst)
      jab_ev |=> (proc_r == txwb_pkg::PROC_STOPPED && int_r[txwb_pkg::INT_JABBER_BIT]
                  && abort_r) ##1 (desc_wr_r && desc_word_r[14]))
      else $error("jabber handling wrong");
   a_underrun_suspend: assert property (@(posedge clk) disable iff (sys_rst)
      uf_ev |=> (proc_r == txwb_pkg::PROC_SUSPENDED && int_r[txwb_pkg::INT_UNDERRUN_BIT])
                ##1 (desc_wr_r && desc_word_r[1] && int_r[txwb_pkg::INT_TX_BIT]))
      else $error("underrun handling wrong");
   a_late_abort: assert property (@(posedge clk) disable iff (sys_rst)
      late_ev |=> abort_r ##1 (desc_wr_r && desc_word_r[9]))
      else $error("late collision not reported");
   a_excess_abort: assert property (@(posedge clk) disable iff (sys_rst)
      (coll_ev && coll_r == 5'h0f && bytes_r != txwb_pkg::COLL_WINDOW_BYTES)
      |=> abort_r ##1 (desc_wr_r && desc_word_r[8]))
      else $error("sixteenth collision not reported");
   a_retry_no_hb: assert property (@(posedge clk) disable iff (sys_rst)
      (desc_wr_r && was_retry_r) |-> !desc_word_r[7])
      else $error("heartbeat failure on retried frame");
   a_sqe_forced: assert property (@(posedge clk) disable iff (sys_rst)
      (fst_r == txwb_pkg::F_HEARTBEAT && hb_cnt_r == 8'h01 && !was_retry_r
       && mode_r.port_mode == txwb_pkg::PORT_TWISTED && !mode_r.sqe_enable)
      |-> ##2 (desc_wr_r && desc_word_r[7]))
      else $error("heartbeat failure not forced");
   a_loop_masks: assert property (@(posedge clk) disable iff (sys_rst)
      (desc_wr_r && $past(mode_r.loopback) == txwb_pkg::LOOP_INTERNAL)
      |-> (desc_word_r[11:10] == 2'h0))
      else $error("carrier flags set in internal loopback");
   a_tally_count: assert property (@(posedge clk) disable iff (sys_rst)
      (fst_r == txwb_pkg::F_HEARTBEAT && hb_cnt_r == 8'h01)
      |-> ##2 (desc_word_r[6:3] == $past(coll_r[3:0], 2)))
      else $error("collision tally wrong");

   c_clean_frame: cover property (@(posedge clk) desc_wr_r && !desc_word_r[15]);
   c_retry_frame: cover property (@(posedge clk) desc_wr_r && desc_word_r[6:3] != 4'h0);
   c_underrun: cover property (@(posedge clk) uf_ev);
   c_jabber: cover property (@(posedge clk) jab_ev);

endmodule

// >>> bench/host_desc_mem.sv
`timescale 1ns/10ps
module host_desc_mem (
   input wire logic clk, // System clock
   input wire logic sys_rst, // Synchronous reset
   input wire logic give, // Host hands the descriptor over
   input wire logic wr_pulse, // Status write from the block
   input wire logic [31:0] wr_word, // Status word written back
   output logic owned_r, // Descriptor held by the controller
   output logic [31:0] word_r // Stored status word
);
   // Word 0 of one descriptor: host hand-over, block write-back
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         owned_r <= 1'b0;
         word_r <= 32'h0000_0000;
      end else if (wr_pulse) begin
         word_r <= wr_word;
         owned_r <= wr_word[31];
      end else if (give) begin
         // One descriptor per frame, so the first is also the last handed over
         word_r[31] <= 1'b1;
         owned_r <= 1'b1;
      end
   end
endmodule

// >>> bench/test_tx_status_writeback.sv
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_tx_status_writeback;
   localparam logic [6:0] E_FS = 7'h01, E_BYTE = 7'h02, E_COLL = 7'h04, E_END = 7'h08;
   localparam logic [6:0] E_UF = 7'h10, E_JAB = 7'h20, E_DEF = 7'h40;
   logic clk, sys_rst, reg_wr, reg_rd, link_fail, carrier_pin, heartbeat_pin, give;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata_r, desc_word_r, word_r, r;
   logic [6:0] ev;
   logic [1:0] proc_state_r;
   logic abort_r, retry_r, desc_wr_r, irq_r, owned_r;
   wire logic frame_start, byte_sent, collision, attempt_end, fifo_empty, jabber_expired;
   wire logic defer_seen;
   int n_fail = 0, n_compared = 0, n_abort = 0, n_retry = 0;
   // Event pulses travel as one vector
   assign {defer_seen, jabber_expired, fifo_empty, attempt_end, collision, byte_sent,
      frame_start} = ev;
   tx_status_writeback u_tx_status_writeback (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r), .frame_start(frame_start), .byte_sent(byte_sent),
      .collision(collision), .attempt_end(attempt_end), .fifo_empty(fifo_empty),
      .jabber_expired(jabber_expired), .defer_seen(defer_seen), .link_fail(link_fail),
      .carrier_pin(carrier_pin), .heartbeat_pin(heartbeat_pin), .abort_r(abort_r),
      .retry_r(retry_r), .desc_wr_r(desc_wr_r), .desc_word_r(desc_word_r),
      .proc_state_r(proc_state_r), .irq_r(irq_r));
   host_desc_mem u_host_desc_mem (.clk(clk), .sys_rst(sys_rst), .give(give),
      .wr_pulse(desc_wr_r), .wr_word(desc_word_r), .owned_r(owned_r), .word_r(word_r));
   // Clock, 10 ns period
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Count abort and retry pulses
   always @(posedge clk) begin
      if (abort_r === 1'b1) n_abort++;
      if (retry_r === 1'b1) n_retry++;
   end
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata_r;
   endtask
   task automatic pulse(input logic [6:0] v);
      @(posedge clk);
      ev <= v;
      @(posedge clk);
      ev <= 7'h00;
   endtask
   task automatic start_frame();
      @(posedge clk);
      give <= 1'b1;
      @(posedge clk);
      give <= 1'b0;
      #1 `CHK(owned_r, 1'b1)
      pulse(E_FS);
   endtask
   // Early collisions, bytes, optional extra event, closing event, heartbeat
   task automatic body(input int nb, input int nc, input logic [6:0] pre,
         input logic [6:0] fin, input bit hb);
      repeat (nc) begin
         repeat (2) pulse(E_BYTE);
         pulse(E_COLL);
      end
      repeat (nb) pulse(E_BYTE);
      if (pre != 7'h00) pulse(pre);
      pulse(fin);
      if (hb) begin
         heartbeat_pin <= 1'b1;
         repeat (5) @(posedge clk);
         heartbeat_pin <= 1'b0;
      end
   endtask
   // Wait for the write-back, then read the word back from host memory
   task automatic wb(input logic [31:0] e, input logic [31:0] m);
      int i;
      for (i = 0; i < 400; i++) begin
         @(posedge clk);
         #1;
         if (desc_wr_r === 1'b1) break;
      end
      if (i == 400) n_fail++;
      @(posedge clk);
      #1 `CHK(word_r & m, e)
      `CHK(owned_r, 1'b0)
   endtask
   task automatic frame(input int nb, input int nc, input logic [6:0] pre,
         input logic [6:0] fin, input bit hb, input logic [31:0] e, input logic [31:0] m);
      start_frame();
      body(nb, nc, pre, fin, hb);
      wb(e, m);
   endtask
   // Watchdog
   initial begin
      #300us;
      n_fail++;
      final_report();
   end
   initial begin
      sys_rst = 1'b1;
      {reg_wr, reg_rd, link_fail, heartbeat_pin, give} = 5'h00;
      carrier_pin = 1'b1;
      reg_addr = 4'h0;
      reg_wdata = 32'h0000_0000;
      ev = 7'h00;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rd(txwb_pkg::REG_MODE);
      `CHK(r, 32'h0000_0000)
      rd(txwb_pkg::REG_INT_MASK);
      `CHK(r, 32'h0000_0000)
      rd(4'h2);
      `CHK(r, 32'h0000_0000)
      wr(txwb_pkg::REG_MODE, 32'h0000_0030);
      rd(txwb_pkg::REG_PROC_STATE);
      `CHK(r[1:0], txwb_pkg::PROC_RUNNING)
      wr(txwb_pkg::REG_PROC_STATE, 32'h0000_0000);
      wr(txwb_pkg::REG_INT_STATUS, 32'h0000_003f);
      rd(txwb_pkg::REG_INT_STATUS);
      `CHK(r, 32'h0000_0000)
      `CHK(proc_state_r, txwb_pkg::PROC_RUNNING)
      $display("test registers done");
      frame(4, 0, 7'h00, E_END, 1, 32'h0000_0000, 32'hffff_ffff);
      `CHK(irq_r, 1'b0)
      wr(txwb_pkg::REG_INT_MASK, 32'h0000_0029);
      repeat (3) @(posedge clk);
      #1 `CHK(irq_r, 1'b1)
      rd(txwb_pkg::REG_INT_STATUS);
      `CHK(r, 32'h0000_0001)
      repeat (3) @(posedge clk);
      #1 `CHK(irq_r, 1'b0)
      frame(4, 0, 7'h00, E_END, 0, 32'h0000_0080, 32'hffff_ffff);
      wr(txwb_pkg::REG_MODE, 32'h0000_0020);
      frame(4, 0, 7'h00, E_END, 1, 32'h0000_0080, 32'hffff_ffff);
      wr(txwb_pkg::REG_MODE, 32'h0000_0024);
      frame(4, 0, 7'h00, E_END, 1, 32'h0000_0000, 32'hffff_ffff);
      wr(txwb_pkg::REG_MODE, 32'h0000_0030);
      $display("test heartbeat done");
      frame(2, 2, E_DEF, E_END, 0, 32'h0000_0011, 32'hffff_ffff);
      `CHK(n_retry, 2)
      frame(64, 0, 7'h00, E_COLL, 0, 32'h0000_8200, 32'hffff_ff7f);
      frame(2, 15, 7'h00, E_COLL, 0, 32'h0000_8100, 32'hffff_ff07);
      `CHK(n_retry, 17)
      $display("test collisions done");
      link_fail <= 1'b1;
      start_frame();
      wb(32'h0000_8004, 32'hffff_ff7f);
      link_fail <= 1'b0;
      rd(txwb_pkg::REG_INT_STATUS);
      frame(5, 0, 7'h00, E_UF, 0, 32'h0000_8002, 32'hffff_ff7f);
      rd(txwb_pkg::REG_PROC_STATE);
      `CHK(r[1:0], txwb_pkg::PROC_SUSPENDED)
      `CHK(proc_state_r, txwb_pkg::PROC_SUSPENDED)
      rd(txwb_pkg::REG_INT_STATUS);
      `CHK(r, 32'h0000_0021)
      wr(txwb_pkg::REG_MODE, 32'h0000_0030);
      frame(5, 0, 7'h00, E_JAB, 0, 32'h0000_c000, 32'hffff_ff7f);
      rd(txwb_pkg::REG_PROC_STATE);
      `CHK(r[1:0], txwb_pkg::PROC_STOPPED)
      `CHK(proc_state_r, txwb_pkg::PROC_STOPPED)
      rd(txwb_pkg::REG_INT_STATUS);
      `CHK(r, 32'h0000_0009)
      `CHK(n_abort, 4)
      $display("test aborts done");
      wr(txwb_pkg::REG_MODE, 32'h0000_0031);
      carrier_pin <= 1'b0;
      frame(4, 0, 7'h00, E_END, 1, 32'h0000_0000, 32'hffff_ffff);
      wr(txwb_pkg::REG_MODE, 32'h0000_0030);
      frame(4, 0, 7'h00, E_END, 1, 32'h0000_8400, 32'hffff_ffff);
      carrier_pin <= 1'b1;
      start_frame();
      body(4, 0, 7'h00, 7'h00, 0);
      carrier_pin <= 1'b0;
      repeat (4) @(posedge clk);
      body(3, 0, 7'h00, E_END, 1);
      wb(32'h0000_8800, 32'hffff_ffff);
      $display("test carrier done");
      final_report();
   end
endmodule
